// ===== design/scg_defs.svh
// Offsets, field positions, reset values and timing counts of the
// system clock generation block.
// Assumes a 200 MHz system clock and an 8-bit register port.
`ifndef SCG_DEFS_SVH
`define SCG_DEFS_SVH

// ==========================================================
// Register offsets on the plain register port
`define SCG_ADDR_TRIM 4'h0
`define SCG_ADDR_DIVISOR 4'h1
`define SCG_ADDR_AUX_ONE 4'h2
`define SCG_ADDR_STATUS 4'h3

// ==========================================================
// Field positions and widths
`define SCG_TRIM_WIDTH 6
`define SCG_TRIM_CLKOUT_BIT 6
`define SCG_AUX_LOWPOWER_BIT 7
`define SCG_STATUS_RUN_BIT 0

// ==========================================================
// Reset values
`define SCG_DIVISOR_RESET 8'h00
`define SCG_LOWPOWER_RESET 1'h0
`define SCG_CLKOUT_ENABLE_RESET 1'h0

// ==========================================================
// Timing
`define SCG_CLOCK_MHZ 200
`define SCG_WAKE_XTAL_CYCLES 10'h3e0
`define SCG_WAKE_OTHER_CYCLES 10'h0e0
`define SCG_WAKE_EXTRA_US 60
`define SCG_WAKE_EXTRA_CYCLES (`SCG_WAKE_EXTRA_US * `SCG_CLOCK_MHZ)
`define SCG_DIV_MAX_COUNT 9'h1fe

`endif

// ===== design/scg_pkg.sv
// Types shared by the system clock generation block.
// Assumes scg_defs.svh for the numeric constants.
package scg_pkg;

	// ==========================================================
	// Oscillator clock source, as set by the configuration bits
	typedef enum logic [2:0] {
		SCG_SRC_RC,
		SCG_SRC_WATCHDOG,
		SCG_SRC_EXTERNAL,
		SCG_SRC_XTAL_LOW,
		SCG_SRC_XTAL_MED,
		SCG_SRC_XTAL_HIGH
	} scg_osc_source_t;

	// Wake-up timer phases
	typedef enum logic [1:0] {
		SCG_WAKE_OSC,
		SCG_WAKE_TIME,
		SCG_WAKE_RUN
	} scg_wake_state_t;

	// Register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wrData;
		logic wrStrobe;
		logic rdStrobe;
	} scg_bus_req_t;

	// Crystal selections need the longer wake-up count
	function automatic logic scg_is_crystal(input scg_osc_source_t src);
		scg_is_crystal = (src == SCG_SRC_XTAL_LOW) ||
			(src == SCG_SRC_XTAL_MED) || (src == SCG_SRC_XTAL_HIGH);
	endfunction : scg_is_crystal

endpackage : scg_pkg

// ===== design/scg_cpu_clock_divider.sv
// CPU clock divider: one cpuTick per 2*divisor oscillator ticks, or per oscillator tick when divisor is 0.
// Assumes oscTick is a one-cycle pulse per oscillator clock edge.
`timescale 1ns/1ps
`include "scg_defs.svh"

module scg_cpu_clock_divider #(
	parameter int DIV_WIDTH = 8
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic oscTick,
	input wire logic run,
	input wire logic [DIV_WIDTH-1:0] divisor,
	output logic cpuTick
);

	typedef struct packed {
		logic [DIV_WIDTH:0] count;
		logic tick;
	} scg_div_state_t;

	scg_div_state_t state_reg;
	scg_div_state_t state_next;
	logic [DIV_WIDTH:0] terminal;

	// Last count of a period; compared with >= so a smaller new value ends
	// the running period at once instead of wrapping
	assign terminal = (DIV_WIDTH+1)'({divisor, 1'b0} - 1'b1);

	// ==========================================================
	// Divider
	always_comb
	begin
		state_next = state_reg;
		state_next.tick = 1'b0;
		if (!run)
		begin
			state_next.count = '0;
		end
		else if (oscTick)
		begin
			if (divisor == '0)
			begin
				state_next.tick = 1'b1;
				state_next.count = '0;
			end
			else if (state_reg.count >= terminal)
			begin
				state_next.tick = 1'b1;
				state_next.count = '0;
			end
			else
			begin
				state_next.count = state_reg.count + 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign cpuTick = state_reg.tick;

	AST_DIV_BYPASS: assert property (@(posedge clock) disable iff (reset)
		run && oscTick && divisor == '0 |=> cpuTick)
		else $error("undivided clock missed a tick");

	AST_DIV_BOUND: assert property (@(posedge clock) disable iff (reset)
		state_reg.count < `SCG_DIV_MAX_COUNT)
		else $error("divider count beyond largest ratio");

	AST_DIV_NO_TICK: assert property (@(posedge clock) disable iff (reset)
		!oscTick || !run |=> !cpuTick)
		else $error("cpu tick without oscillator tick");

endmodule : scg_cpu_clock_divider

// ===== design/scg_wakeup_timer.sv
// Wake-up timer: holds the CPU clock for an oscillator count plus a
// fixed time after reset. Assumes oscTick pulses per oscillator edge.
`timescale 1ns/1ps
`include "scg_defs.svh"

module scg_wakeup_timer #(
	parameter int EXTRA_CYCLES = `SCG_WAKE_EXTRA_CYCLES
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic oscTick,
	input wire logic crystal,
	output logic running
);

	localparam int TW = $clog2(EXTRA_CYCLES + 1);

	typedef struct packed {
		scg_pkg::scg_wake_state_t phase;
		logic [9:0] oscCount;
		logic [TW-1:0] timeCount;
		logic running;
	} scg_wake_t;

	scg_wake_t state_reg;
	scg_wake_t state_next;
	logic [9:0] oscTarget;

	// Crystal sources settle slower
	assign oscTarget = crystal ? `SCG_WAKE_XTAL_CYCLES :
		`SCG_WAKE_OTHER_CYCLES;

	// ==========================================================
	// Phase sequencing
	always_comb
	begin
		state_next = state_reg;
		case (state_reg.phase)
			scg_pkg::SCG_WAKE_OSC:
			begin
				if (oscTick)
				begin
					if (state_reg.oscCount == oscTarget - 10'h001)
					begin
						state_next.phase = scg_pkg::SCG_WAKE_TIME;
					end
					state_next.oscCount = state_reg.oscCount + 10'h001;
				end
			end
			scg_pkg::SCG_WAKE_TIME:
			begin
				if (state_reg.timeCount == TW'(EXTRA_CYCLES - 1))
				begin
					state_next.phase = scg_pkg::SCG_WAKE_RUN;
					state_next.running = 1'b1;
				end
				state_next.timeCount = state_reg.timeCount + 1'b1;
			end
			scg_pkg::SCG_WAKE_RUN:
			begin
				state_next.running = 1'b1;
			end
			default:
			begin
				state_next.phase = scg_pkg::SCG_WAKE_OSC;
			end
		endcase
	end

	// State register
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign running = state_reg.running;

	sequence oscPhaseEnd;
		state_reg.phase == scg_pkg::SCG_WAKE_OSC && oscTick &&
			state_reg.oscCount == oscTarget - 10'h001;
	endsequence

	sequence timePhaseStart;
		state_reg.phase == scg_pkg::SCG_WAKE_TIME && !running;
	endsequence

	AST_WAKE_XTAL: assert property (@(posedge clock) disable iff (reset)
		(oscPhaseEnd and crystal) |-> state_reg.oscCount == 10'h3df
			##1 timePhaseStart)
		else $error("crystal wake count wrong");

	AST_WAKE_OTHER: assert property (@(posedge clock) disable iff (reset)
		(oscPhaseEnd and !crystal) |-> state_reg.oscCount == 10'h0df
			##1 timePhaseStart)
		else $error("non-crystal wake count wrong");

	AST_WAKE_TIME: assert property (@(posedge clock) disable iff (reset)
		$rose(running) |-> $past(state_reg.timeCount) == TW'(EXTRA_CYCLES - 1))
		else $error("wake time not observed");

endmodule : scg_wakeup_timer

// ===== design/scg_system_clock_generation.sv
// Top of the system clock generation block: source select, wake-up
// hold-off, CPU divider, peripheral and output clocks, registers.
// Assumes oscillator ticks and pins synchronous to clock; powerOnReset
// comes with reset on power-up only.
//
// Behaviour
// - Software writes a 6-bit trim value that tunes the internal RC oscillator.
// - On power-on reset the trim value loads the factory setting for nominal frequency.
// - Only power-on reset reloads trim; other resets keep it unchanged.
// - The 400 kHz watchdog oscillator is a selectable oscillator source.
// - External mode takes the clock pin, 0 Hz to 12 MHz; partner pin freed.
// - Crystal sources hold the CPU clock 992 oscillator cycles plus 60-100 us.
// - RC, watchdog or external hold the CPU clock 224 cycles plus 60-100 us.
// - The CPU clock comes through a divider with largest ratio 510.
// - Divider changes take effect any time without corrupting execution.
// - Low-power access bit at bit 7; software sets it only at 8 MHz or below.
// - Every reset clears the low-power access bit.
// - Peripheral clock is half CPU clock; machine cycle spans two CPU clocks.
// - With clock-out enabled and no crystal, drive half CPU clock out.
`timescale 1ns/1ps
`include "scg_defs.svh"

module scg_system_clock_generation #(
	parameter int WAKE_EXTRA_CYCLES = `SCG_WAKE_EXTRA_CYCLES
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic powerOnReset,
	input wire logic [5:0] factoryTrim,
	input wire logic [2:0] oscillatorSelect,
	input wire logic rcOscTick,
	input wire logic watchdogOscTick,
	input wire logic crystalOscTick,
	input wire logic externalClockInPin,
	input wire scg_pkg::scg_bus_req_t busReq,
	output logic [7:0] rdData,
	output logic [5:0] rcTrim,
	output logic oscillatorClock,
	output logic cpuClock,
	output logic peripheralClock,
	output logic cpuClockRunning,
	output logic lowSpeedPowerSave,
	output logic clockOutPinOut,
	output logic clockOutPinOe
);

	// ==========================================================
	// State types
	typedef struct packed {
		logic extPinLevel;
		logic extPinPrev;
		logic oscTick;
		logic [7:0] cpuClockDivisor;
		logic lowSpeedPowerSave;
		logic periphPhase;
		logic periphTick;
		logic clockOutLevel;
		logic clockOutOe;
		logic [7:0] rdData;
	} scg_main_t;

	typedef struct packed {
		logic [5:0] trim;
		logic clockOutEnable;
	} scg_trim_t;

	scg_main_t state_reg;
	scg_main_t state_next;
	scg_trim_t trim_reg;
	scg_trim_t trim_next;
	scg_pkg::scg_osc_source_t source;
	logic crystal;
	logic extRise;
	logic cpuTick;
	logic running;
	logic wrTrim;
	logic wrDivisor;
	logic wrAux;

	// Address match used by the write strobe decode
	function automatic logic scg_hit(input logic [3:0] addr,
		input logic [3:0] target);
		scg_hit = (addr == target);
	endfunction : scg_hit

	// ==========================================================
	// Source decode; undefined codes fall back to the RC oscillator
	always_comb
	begin
		case (oscillatorSelect)
			3'h1: source = scg_pkg::SCG_SRC_WATCHDOG;
			3'h2: source = scg_pkg::SCG_SRC_EXTERNAL;
			3'h3: source = scg_pkg::SCG_SRC_XTAL_LOW;
			3'h4: source = scg_pkg::SCG_SRC_XTAL_MED;
			3'h5: source = scg_pkg::SCG_SRC_XTAL_HIGH;
			default: source = scg_pkg::SCG_SRC_RC;
		endcase
	end

	assign crystal = scg_pkg::scg_is_crystal(source);
	assign extRise = state_reg.extPinLevel && !state_reg.extPinPrev;

	// Write strobes; only the trim strobe is blocked while reset is active
	assign wrTrim = busReq.wrStrobe && !reset &&
		scg_hit(busReq.addr, `SCG_ADDR_TRIM);
	assign wrDivisor = busReq.wrStrobe &&
		scg_hit(busReq.addr, `SCG_ADDR_DIVISOR);
	assign wrAux = busReq.wrStrobe &&
		scg_hit(busReq.addr, `SCG_ADDR_AUX_ONE);

	// ==========================================================
	// Sub-blocks
	scg_cpu_clock_divider #(
		.DIV_WIDTH(8)
	) u_divider (
		.clock(clock),
		.reset(reset),
		.oscTick(state_reg.oscTick),
		.run(running),
		.divisor(state_reg.cpuClockDivisor),
		.cpuTick(cpuTick)
	);

	scg_wakeup_timer #(
		.EXTRA_CYCLES(WAKE_EXTRA_CYCLES)
	) u_wakeup (
		.clock(clock),
		.reset(reset),
		.oscTick(state_reg.oscTick),
		.crystal(crystal),
		.running(running)
	);

	// ==========================================================
	// Main next-state logic
	always_comb
	begin
		state_next = state_reg;
		// External pin rising edges become oscillator ticks; a still pin stops them
		state_next.extPinLevel = externalClockInPin;
		state_next.extPinPrev = state_reg.extPinLevel;
		// Oscillator clock select
		case (source)
			scg_pkg::SCG_SRC_WATCHDOG: state_next.oscTick = watchdogOscTick;
			scg_pkg::SCG_SRC_EXTERNAL: state_next.oscTick = extRise;
			scg_pkg::SCG_SRC_XTAL_LOW,
			scg_pkg::SCG_SRC_XTAL_MED,
			scg_pkg::SCG_SRC_XTAL_HIGH: state_next.oscTick = crystalOscTick;
			default: state_next.oscTick = rcOscTick;
		endcase
		// Divider value may be written at any time
		if (wrDivisor)
		begin
			state_next.cpuClockDivisor = busReq.wrData;
		end
		// Low-power access bit
		if (wrAux)
		begin
			state_next.lowSpeedPowerSave =
				busReq.wrData[`SCG_AUX_LOWPOWER_BIT];
		end
		// Peripheral clock: every second CPU tick
		state_next.periphTick = cpuTick && state_reg.periphPhase;
		if (cpuTick)
		begin
			state_next.periphPhase = !state_reg.periphPhase;
		end
		// Clock output on the crystal's partner pin
		if (trim_reg.clockOutEnable && !crystal)
		begin
			state_next.clockOutOe = 1'b1;
			if (cpuTick)
			begin
				state_next.clockOutLevel = !state_reg.clockOutLevel;
			end
		end
		else
		begin
			state_next.clockOutOe = 1'b0;
			state_next.clockOutLevel = 1'b0;
		end
		// Read data stand for one cycle only
		state_next.rdData = 8'h00;
		if (busReq.rdStrobe)
		begin
			case (busReq.addr)
				`SCG_ADDR_TRIM:
				begin
					state_next.rdData = {1'b0, trim_reg.clockOutEnable,
						trim_reg.trim};
				end
				`SCG_ADDR_DIVISOR:
				begin
					state_next.rdData = state_reg.cpuClockDivisor;
				end
				`SCG_ADDR_AUX_ONE:
				begin
					state_next.rdData = {state_reg.lowSpeedPowerSave, 7'h00};
				end
				`SCG_ADDR_STATUS:
				begin
					state_next.rdData = {4'h0, oscillatorSelect, running};
				end
				default:
				begin
					state_next.rdData = 8'h00;
				end
			endcase
		end
	end

	// Main state register; every reset clears low-power access
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			state_reg <= '0;
			state_reg.cpuClockDivisor <= `SCG_DIVISOR_RESET;
			state_reg.lowSpeedPowerSave <= `SCG_LOWPOWER_RESET;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// Trim register, kept across every reset except power-on
	always_comb
	begin
		trim_next = trim_reg;
		if (powerOnReset)
		begin
			trim_next.trim = factoryTrim;
			trim_next.clockOutEnable = `SCG_CLKOUT_ENABLE_RESET;
		end
		else if (wrTrim)
		begin
			trim_next.trim = busReq.wrData[5:0];
			trim_next.clockOutEnable = busReq.wrData[`SCG_TRIM_CLKOUT_BIT];
		end
	end

	// No asynchronous reset here: ordinary resets must leave trim alone
	always_ff @(posedge clock)
	begin
		trim_reg <= trim_next;
	end

	// ==========================================================
	// Outputs
	assign rdData = state_reg.rdData;
	assign rcTrim = trim_reg.trim;
	assign oscillatorClock = state_reg.oscTick;
	assign cpuClock = cpuTick;
	assign peripheralClock = state_reg.periphTick;
	assign cpuClockRunning = running;
	assign lowSpeedPowerSave = state_reg.lowSpeedPowerSave;
	assign clockOutPinOut = state_reg.clockOutLevel;
	assign clockOutPinOe = state_reg.clockOutOe;

	// ==========================================================
	// Assertions
	AST_TRIM_WRITE: assert property (@(posedge clock) disable iff (reset)
		wrTrim && !powerOnReset |=> rcTrim == $past(busReq.wrData[5:0]))
		else $error("trim write not stored");

	AST_TRIM_POR: assert property (@(posedge clock) disable iff (1'b0)
		powerOnReset |=> rcTrim == $past(factoryTrim))
		else $error("power-on did not load factory trim");

	AST_TRIM_HOLD: assert property (@(posedge clock) disable iff (powerOnReset)
		!wrTrim |=> $stable(rcTrim))
		else $error("trim changed without write or power-on");

	AST_WDOG_SRC: assert property (@(posedge clock) disable iff (reset)
		source == scg_pkg::SCG_SRC_WATCHDOG |=>
			oscillatorClock == $past(watchdogOscTick))
		else $error("watchdog oscillator not selected");

	AST_EXT_SRC: assert property (@(posedge clock) disable iff (reset)
		source == scg_pkg::SCG_SRC_EXTERNAL && !$past(externalClockInPin) &&
			externalClockInPin ##1 source == scg_pkg::SCG_SRC_EXTERNAL
			|=> oscillatorClock)
		else $error("external pin edge lost");

	AST_LOWPWR_WRITE: assert property (@(posedge clock) disable iff (reset)
		wrAux |=> lowSpeedPowerSave == $past(busReq.wrData[7]))
		else $error("low-power bit not stored");

	AST_LOWPWR_RESET: assert property (@(posedge clock) disable iff (reset)
		$past(reset) |-> !lowSpeedPowerSave)
		else $error("low-power bit not cleared by reset");

	AST_PERIPH: assert property (@(posedge clock) disable iff (reset)
		peripheralClock |-> $past(cpuTick) && !state_reg.periphPhase)
		else $error("peripheral clock not half of cpu clock");

	AST_CLKOUT: assert property (@(posedge clock) disable iff (reset)
		cpuTick && clockOutPinOe && trim_reg.clockOutEnable && !crystal
			|=> clockOutPinOut != $past(clockOutPinOut))
		else $error("clock output did not toggle");

	AST_HOLDOFF: assert property (@(posedge clock) disable iff (reset)
		!running |=> !cpuClock)
		else $error("cpu clock during wake-up hold-off");

	AST_READ_ONCE: assert property (@(posedge clock) disable iff (reset)
		!busReq.rdStrobe |=> rdData == 8'h00)
		else $error("read data outside read answer cycle");

endmodule : scg_system_clock_generation

// ===== verif/scg_osc_model.sv
// Oscillators and external clock source seen by the clock block.
// Assumes one free-running system clock; ticks are one-cycle pulses.
`timescale 1ns/1ps

module scg_osc_model #(
	parameter int RC_P = 12,
	parameter int WD_P = 14,
	parameter int XT_P = 13,
	parameter int EXT_P = 18
) (
	input wire logic clock,
	output logic rcOscTick,
	output logic watchdogOscTick,
	output logic crystalOscTick,
	output logic externalClockInPin
);
	// ========
	// Free-running sources, all kept at or below 18 MHz
	int t = 0;

	// Distinct periods and phases so a wrong source selection shows
	always @(posedge clock)
	begin
		t <= t + 1;
		rcOscTick <= (t % RC_P) == 0;
		watchdogOscTick <= (t % WD_P) == 3;
		crystalOscTick <= (t % XT_P) == 5;
		externalClockInPin <= (t % EXT_P) < (EXT_P / 2);
	end
endmodule : scg_osc_model

// ===== verif/scg_system_clock_generation_tb_top.sv
// Self-checking testbench for the system clock generation block.
// Assumes scg_osc_model supplies every oscillator tick and pin clock.
`timescale 1ns/1ps

module scg_system_clock_generation_tb_top;
	// ========
	// Settings, stimulus and observed signals
	localparam int RC_P = 12;
	localparam int WD_P = 14;
	localparam int XT_P = 13;
	localparam int EXT_P = 18;
	localparam int EXTRA = 4;
	localparam logic [5:0] FACTORY = 6'h2b;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic powerOnReset = 1'b1;
	logic [5:0] factoryTrim = FACTORY;
	logic [2:0] oscillatorSelect = 3'h0;
	scg_pkg::scg_bus_req_t busReq = '0;
	logic rcOscTick, watchdogOscTick, crystalOscTick, externalClockInPin;
	logic [7:0] rdData;
	logic [5:0] rcTrim;
	logic oscillatorClock, cpuClock, peripheralClock, cpuClockRunning;
	logic lowSpeedPowerSave, clockOutPinOut, clockOutPinOe;
	int errors = 0;
	int n_checks = 0;
	int cycles = 0;
	int per[6] = '{RC_P, WD_P, EXT_P, XT_P, XT_P, XT_P};
	logic [7:0] divs[4] = '{8'h00, 8'h01, 8'h03, 8'hff};

	scg_system_clock_generation #(.WAKE_EXTRA_CYCLES(EXTRA))
		scg_system_clock_generation_i (.clock(clock), .reset(reset),
		.powerOnReset(powerOnReset), .factoryTrim(factoryTrim),
		.oscillatorSelect(oscillatorSelect), .rcOscTick(rcOscTick),
		.watchdogOscTick(watchdogOscTick), .crystalOscTick(crystalOscTick),
		.externalClockInPin(externalClockInPin), .busReq(busReq),
		.rdData(rdData), .rcTrim(rcTrim), .oscillatorClock(oscillatorClock),
		.cpuClock(cpuClock), .peripheralClock(peripheralClock),
		.cpuClockRunning(cpuClockRunning),
		.lowSpeedPowerSave(lowSpeedPowerSave),
		.clockOutPinOut(clockOutPinOut), .clockOutPinOe(clockOutPinOe));

	scg_osc_model #(.RC_P(RC_P), .WD_P(WD_P), .XT_P(XT_P), .EXT_P(EXT_P))
		scg_osc_model_i (.clock(clock), .rcOscTick(rcOscTick),
		.watchdogOscTick(watchdogOscTick), .crystalOscTick(crystalOscTick),
		.externalClockInPin(externalClockInPin));

	// 200 MHz clock
	initial
	begin
		forever #2.5 clock = ~clock;
	end

	// Hang guard
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 95000)
		begin
			errors++;
			report_and_stop;
		end
	end

	// ========
	// Shared tasks
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		busReq <= '{addr: a, wrData: d, wrStrobe: 1'b1, rdStrobe: 1'b0};
		@(posedge clock);
		busReq <= '0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clock);
		busReq <= '{addr: a, wrData: 8'h00, wrStrobe: 1'b0, rdStrobe: 1'b1};
		@(posedge clock);
		busReq <= '0;
		#1;
		chk({8'h00, rdData}, {8'h00, exp});
	endtask : rdchk

	task automatic do_reset(input logic por, input logic [2:0] sel);
		@(posedge clock);
		reset <= 1'b1;
		powerOnReset <= por;
		oscillatorSelect <= sel;
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		powerOnReset <= 1'b0;
	endtask : do_reset

	task automatic wait_run;
		int c = 0;
		while (cpuClockRunning !== 1'b1 && c < 20000)
		begin
			@(posedge clock);
			c++;
		end
	endtask : wait_run

	// Cycles until the next CPU clock pulse
	task automatic wait_cpu(output int c);
		c = 0;
		do
		begin
			@(posedge clock);
			#1;
			c++;
		end
		while (cpuClock !== 1'b1 && c < 8000);
	endtask : wait_cpu

	// ========
	// Scenarios
	task automatic t_regs;
		rdchk(4'h0, {2'b00, FACTORY});
		rdchk(4'h2, 8'h00);
		wr(4'h0, 8'hbf);
		rdchk(4'h0, 8'h3f);
		chk({10'h000, rcTrim}, 16'h003f);
		wr(4'h9, 8'hff);
		rdchk(4'h9, 8'h00);
		wr(4'h1, 8'h02);
		wr(4'h2, 8'h80);
		rdchk(4'h2, 8'h80);
		chk({15'h0000, lowSpeedPowerSave}, 16'h0001);
		factoryTrim <= 6'h11;
		do_reset(1'b0, 3'h0);
		rdchk(4'h0, 8'h3f);
		rdchk(4'h2, 8'h00);
		chk({15'h0000, lowSpeedPowerSave}, 16'h0000);
		do_reset(1'b1, 3'h0);
		rdchk(4'h0, 8'h11);
		wait_run;
		$display("register test done");
	endtask : t_regs

	task automatic t_clk;
		int g;
		int nCpu = 0;
		int nPer = 0;
		int nTog = 0;
		logic lastOut;
		foreach (divs[i])
		begin
			wr(4'h1, divs[i]);
			wait_cpu(g);
			wait_cpu(g);
			wait_cpu(g);
			chk(16'(g), 16'(divs[i] == 0 ? RC_P : 2 * divs[i] * RC_P));
		end
		// A smaller divisor cuts the running long period short
		wait_cpu(g);
		wr(4'h1, 8'h01);
		wait_cpu(g);
		chk(16'(g <= 3 * RC_P), 16'h0001);
		wr(4'h0, 8'h7f);
		lastOut = clockOutPinOut;
		repeat (480)
		begin
			@(posedge clock);
			#1;
			nCpu += int'(cpuClock);
			nPer += int'(peripheralClock);
			if (clockOutPinOut !== lastOut)
				nTog++;
			lastOut = clockOutPinOut;
		end
		chk(16'(nCpu >= 19), 16'h0001);
		chk(16'(nPer >= nCpu / 2 - 1 && nPer <= nCpu / 2 + 1), 16'h0001);
		chk(16'(nTog >= nCpu - 1 && nTog <= nCpu + 1), 16'h0001);
		chk({15'h0000, clockOutPinOe}, 16'h0001);
		$display("divider test done");
	endtask : t_clk

	task automatic wake(input logic [2:0] sel, input int p);
		int pulses = 0;
		int cyc = 0;
		logic xtal;
		int w;
		xtal = sel >= 3'h3;
		w = xtal ? 992 : 224;
		do_reset(1'b0, sel);
		while (cpuClockRunning !== 1'b1 && cyc < 20000)
		begin
			@(posedge clock);
			#1;
			cyc++;
			if (oscillatorClock === 1'b1)
				pulses++;
		end
		chk(16'(pulses >= w && pulses <= w + 1), 16'h0001);
		chk(16'(cyc >= (w - 1) * p && cyc <= (w + 1) * p + EXTRA + 4), 16'h0001);
		@(posedge clock);
		#1;
		chk({15'h0000, clockOutPinOe}, {15'h0000, !xtal});
		$display("wake test done for source %0d", sel);
	endtask : wake

	// ========
	// Main sequence
	initial
	begin
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		powerOnReset <= 1'b0;
		wait_run;
		t_regs;
		t_clk;
		for (int s = 0; s < 6; s++)
			wake(3'(s), per[s]);
		report_and_stop;
	end
endmodule : scg_system_clock_generation_tb_top
